// [src/smu_device.sv]
// Purpose: translation shell, request lookup, walk, programming and maintenance
// Assumes: one transaction in flight, single-level walk table
// Notes: data channels travel beside this block unchanged
`timescale 1ns/10ps
module smu_device #(
   parameter smu_pkg::smu_mode_t MODE = smu_pkg::MODE_AXI3,
   parameter bit WALK_PORT = 1'b1,
   parameter bit ADDR_SLICE = 1'b0,
   parameter int TLB_N = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // upstream, programming and maintenance link
   smu_link_if.dev lnk,
   // downstream master port, address side
   output logic down_valid,
   input wire logic down_ready,
   output logic down_write,
   output logic [smu_pkg::OA_W-1:0] down_addr,
   output logic [2:0] down_prot,
   output logic [1:0] down_lock,
   output logic down_bar,
   output logic [smu_pkg::CTX_W-1:0] down_ctx,
   output logic down_secure,
   // walk read port
   output logic walk_arvalid,
   input wire logic walk_arready,
   output logic [smu_pkg::OA_W-1:0] walk_araddr,
   input wire logic walk_rvalid,
   input wire logic [smu_pkg::WD_W-1:0] walk_rdata
);
   import smu_pkg::*;
   localparam int VPN_W = IA_W - PG_W;
   localparam int PPN_W = OA_W - PG_W;
   localparam int VIC_W = (TLB_N > 1) ? $clog2(TLB_N) : 1;
   localparam bit DVM_OK = (MODE == MODE_ACEL) || WALK_PORT;

   // refuse sizes the victim pointer cannot serve
   if (TLB_N < 1 || TLB_N > 16) begin : g_bad_tlb
      $error("TLB_N must be 1 to 16");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SLICE = 3'b001,
      ST_LOOK = 3'b010,
      ST_WAR = 3'b011,
      ST_WR = 3'b100,
      ST_OUT = 3'b101
   } smu_st_t;

   smu_st_t st_r;
   logic [CTX_W-1:0] smap_r [2**SID_W];
   logic [31:0] ttb_r [CTX_N];
   logic [31:0] ssd_r;
   logic [31:0] cnt_ref_r, cnt_rd_r, cnt_wr_r;
   logic tlb_v_r [TLB_N];
   logic [CTX_W-1:0] tlb_ctx_r [TLB_N];
   logic [VPN_W-1:0] tlb_vpn_r [TLB_N];
   logic [PPN_W-1:0] tlb_ppn_r [TLB_N];
   logic [VIC_W-1:0] vic_r;
   logic cur_write_r, cur_sec_r, cur_bar_r;
   logic [IA_W-1:0] cur_addr_r;
   logic [2:0] cur_prot_r;
   logic [1:0] cur_lock_r;
   logic [CTX_W-1:0] cur_ctx_r;
   logic req_ready_r, pready_r, pslverr_r, ac_ready_r, sync_pend_r, sync_done_r;
   logic [31:0] prdata_r;
   logic hit;
   logic [PPN_W-1:0] hit_ppn;
   logic apb_go, apb_wr, fill, fill_ok, dvm_take, do_tlbi_all, sync_req, req_take;
   logic [IDX_W-1:0] idx;

   // word index of a programming address
   function automatic logic [IDX_W-1:0] reg_index(input logic [31:0] a);
      return a[15:2];
   endfunction : reg_index

   assign lnk.req_ready = req_ready_r;
   assign lnk.prdata = prdata_r;
   assign lnk.pready = pready_r;
   assign lnk.pslverr = pslverr_r;
   assign lnk.ac_ready = ac_ready_r;
   assign lnk.sync_done = sync_done_r;

   assign idx = reg_index(lnk.paddr);
   assign apb_go = (lnk.psel_s | lnk.psel_ns) & lnk.penable & lnk.pclken & ~pready_r;
   assign apb_wr = apb_go & lnk.pwrite;
   assign req_take = lnk.req_valid & req_ready_r;
   assign dvm_take = lnk.ac_valid & ac_ready_r;
   assign fill = (st_r == ST_WR) & walk_rvalid;
   assign fill_ok = fill & walk_rdata[DESC_V_BIT];
   assign do_tlbi_all = (dvm_take & (lnk.ac_op == DVM_TLBI_ALL)) | (apb_wr & (idx == REG_TLBI));
   assign sync_req = (dvm_take & (lnk.ac_op == DVM_SYNC)) | (apb_wr & (idx == REG_SYNC));

   // tlb compare on the held request
   always_comb begin
      hit = 1'b0;
      hit_ppn = '0;
      for (int i = 0; i < TLB_N; i++) begin
         if (tlb_v_r[i] && tlb_ctx_r[i] == cur_ctx_r && tlb_vpn_r[i] == cur_addr_r[IA_W-1:PG_W]) begin
            hit = 1'b1;
            hit_ppn = tlb_ppn_r[i];
         end
      end
   end

   // programming port, one wait state, moves only on enabled edges
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (lnk.pclken) begin
         pready_r <= apb_go;
         pslverr_r <= apb_go & (idx == REG_SSD) & ~lnk.psel_s;
         if (apb_go) begin
            unique casez (idx)
               14'b0000_0000_00????: prdata_r <= 32'(smap_r[idx[SID_W-1:0]]);
               14'b0000_0001_000???: prdata_r <= ttb_r[idx[CTX_W-1:0]];
               REG_SSD: prdata_r <= lnk.psel_s ? ssd_r : 32'h0000_0000;
               REG_CNT_REF: prdata_r <= cnt_ref_r;
               REG_CNT_RD: prdata_r <= cnt_rd_r;
               REG_CNT_WR: prdata_r <= cnt_wr_r;
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   // mapping, table base and security tables
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 2**SID_W; i++) smap_r[i] <= '0;
         for (int i = 0; i < CTX_N; i++) ttb_r[i] <= 32'h0000_0000;
         ssd_r <= SSD_RST;
      end else if (apb_wr) begin
         if (idx[IDX_W-1:SID_W] == REG_SMAP[IDX_W-1:SID_W])
            smap_r[idx[SID_W-1:0]] <= lnk.pwdata[CTX_W-1:0];
         if (idx[IDX_W-1:CTX_W] == REG_TTB[IDX_W-1:CTX_W])
            ttb_r[idx[CTX_W-1:0]] <= lnk.pwdata;
         if (idx == REG_SSD && lnk.psel_s)
            ssd_r <= lnk.pwdata;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ref_r <= 32'h0000_0000;
         cnt_rd_r <= 32'h0000_0000;
         cnt_wr_r <= 32'h0000_0000;
      end else begin
         cnt_ref_r <= ((apb_wr && idx == REG_CNT_REF) ? 32'h0000_0000 : cnt_ref_r)
            + 32'(fill_ok);
         cnt_rd_r <= ((apb_wr && idx == REG_CNT_RD) ? 32'h0000_0000 : cnt_rd_r)
            + 32'(req_take & ~lnk.req_write & ~lnk.req_bar);
         cnt_wr_r <= ((apb_wr && idx == REG_CNT_WR) ? 32'h0000_0000 : cnt_wr_r)
            + 32'(req_take & lnk.req_write & ~lnk.req_bar);
      end
   end

   // tlb fill and invalidation
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         vic_r <= '0;
         for (int i = 0; i < TLB_N; i++) begin
            tlb_v_r[i] <= 1'b0;
            tlb_ctx_r[i] <= '0;
            tlb_vpn_r[i] <= '0;
            tlb_ppn_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < TLB_N; i++) begin
            if (do_tlbi_all || (dvm_take && lnk.ac_op == DVM_TLBI_CTX && tlb_ctx_r[i] == lnk.ac_ctx))
               tlb_v_r[i] <= 1'b0;
         end
         if (fill_ok) begin
            tlb_v_r[vic_r] <= 1'b1;
            tlb_ctx_r[vic_r] <= cur_ctx_r;
            tlb_vpn_r[vic_r] <= cur_addr_r[IA_W-1:PG_W];
            tlb_ppn_r[vic_r] <= walk_rdata[OA_W-1:PG_W];
            vic_r <= (32'(vic_r) == TLB_N - 1) ? '0 : vic_r + 1'b1;
         end
      end
   end

   // maintenance acceptance and sync toward the buffer side
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ac_ready_r <= 1'b0;
         sync_pend_r <= 1'b0;
         sync_done_r <= 1'b0;
      end else begin
         ac_ready_r <= DVM_OK & lnk.ac_valid & ~ac_ready_r & (st_r == ST_IDLE);
         sync_done_r <= sync_pend_r & (st_r == ST_IDLE);
         sync_pend_r <= sync_req | (sync_pend_r & (st_r != ST_IDLE));
      end
   end

   // request sequence: capture, lookup, walk, issue
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_IDLE;
         req_ready_r <= 1'b0;
         {cur_write_r, cur_sec_r, cur_bar_r} <= 3'b000;
         cur_addr_r <= '0;
         cur_prot_r <= 3'b000;
         cur_lock_r <= 2'b00;
         cur_ctx_r <= '0;
         walk_arvalid <= 1'b0;
         walk_araddr <= '0;
         down_valid <= 1'b0;
         {down_write, down_bar, down_secure} <= 3'b000;
         down_addr <= '0;
         down_prot <= 3'b000;
         down_lock <= 2'b00;
         down_ctx <= '0;
      end else begin
         unique case (st_r)
            ST_IDLE: begin
               req_ready_r <= ~req_take;
               if (req_take) begin
                  cur_write_r <= lnk.req_write;
                  cur_addr_r <= lnk.req_addr;
                  cur_prot_r <= lnk.req_prot;
                  cur_bar_r <= lnk.req_bar;
                  cur_lock_r <= (MODE == MODE_AXI3) ? (lnk.req_lock & 2'b01) : lnk.req_lock;
                  cur_ctx_r <= smap_r[lnk.req_sid];
                  cur_sec_r <= ssd_r[lnk.req_ssd];
                  st_r <= ADDR_SLICE ? ST_SLICE : ST_LOOK;
               end
            end
            ST_SLICE: st_r <= ST_LOOK;
            ST_LOOK: begin
               if (hit || cur_bar_r) begin
                  down_addr <= cur_bar_r ? OA_W'(cur_addr_r) : {hit_ppn, cur_addr_r[PG_W-1:0]};
                  down_valid <= 1'b1;
                  down_write <= cur_write_r;
                  down_prot <= cur_prot_r;
                  down_lock <= cur_lock_r;
                  down_bar <= cur_bar_r;
                  down_ctx <= cur_ctx_r;
                  down_secure <= cur_sec_r;
                  st_r <= ST_OUT;
               end else begin
                  walk_araddr <= {ttb_r[cur_ctx_r], TTB_SH'(0)}
                     + OA_W'({cur_addr_r[PG_W+WIX_W-1:PG_W], 3'b000});
                  walk_arvalid <= 1'b1;
                  st_r <= ST_WAR;
               end
            end
            ST_WAR: begin
               if (walk_arready) begin
                  walk_arvalid <= 1'b0;
                  st_r <= ST_WR;
               end
            end
            ST_WR: begin
               // invalid descriptor terminates the request
               if (fill) begin
                  st_r <= fill_ok ? ST_LOOK : ST_IDLE;
                  req_ready_r <= ~fill_ok;
               end
            end
            ST_OUT: begin
               if (down_ready) begin
                  down_valid <= 1'b0;
                  req_ready_r <= 1'b1;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule : smu_device

// [src/smu_host.sv]
// Purpose: system end: upstream master, programming master and snoop source
// Assumes: one request in flight, programming divided from ref_clk
// Notes: user side commands become link traffic
`timescale 1ns/10ps
module smu_host #(
   parameter int PCLK_DIV = 1,
   parameter bit DVM_PRESENT = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // link toward the shell
   smu_link_if.sys lnk,
   // transaction commands
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [smu_pkg::IA_W-1:0] cmd_addr,
   input wire logic [2:0] cmd_prot,
   input wire logic [1:0] cmd_lock,
   input wire logic [smu_pkg::SID_W-1:0] cmd_sid,
   input wire logic [smu_pkg::SSD_W-1:0] cmd_ssd,
   input wire logic cmd_bar,
   // register access commands
   input wire logic reg_valid,
   output logic reg_ready,
   input wire logic reg_write,
   input wire logic reg_secure,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_err,
   output logic reg_done,
   // maintenance commands
   input wire logic mnt_valid,
   output logic mnt_ready,
   input wire logic [1:0] mnt_op,
   input wire logic [smu_pkg::CTX_W-1:0] mnt_ctx,
   output logic sync_seen
);
   import smu_pkg::*;

   if (PCLK_DIV < 1 || PCLK_DIV > 256) begin : g_bad_div
      $error("PCLK_DIV must be 1 to 256");
   end

   typedef enum logic [1:0] {
      AP_IDLE = 2'b00,
      AP_SETUP = 2'b01,
      AP_ACC = 2'b10
   } smu_ap_t;

   smu_ap_t ap_r;
   logic [7:0] div_r;
   logic pclken_r, pend_r, p_wr_r, p_sec_r;
   logic [31:0] p_addr_r, p_wdata_r;

   assign lnk.pclken = pclken_r;

   // divide of one keeps enable high
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 8'h00;
         pclken_r <= 1'b1;
      end else begin
         div_r <= (32'(div_r) == PCLK_DIV - 1) ? 8'h00 : div_r + 8'h01;
         pclken_r <= (PCLK_DIV == 1) || (32'(div_r) == PCLK_DIV - 2);
      end
   end

   // one request at a time, in order
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_ready <= 1'b0;
         lnk.req_valid <= 1'b0;
         lnk.req_write <= 1'b0;
         lnk.req_addr <= '0;
         lnk.req_prot <= 3'b000;
         lnk.req_lock <= 2'b00;
         lnk.req_sid <= '0;
         lnk.req_ssd <= '0;
         lnk.req_bar <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         cmd_ready <= 1'b0;
         lnk.req_valid <= 1'b1;
         lnk.req_write <= cmd_write;
         lnk.req_addr <= cmd_addr;
         lnk.req_prot <= cmd_prot;
         lnk.req_lock <= cmd_lock;
         lnk.req_sid <= cmd_sid;
         lnk.req_ssd <= cmd_ssd;
         lnk.req_bar <= cmd_bar;
      end else if (lnk.req_valid && lnk.req_ready) begin
         lnk.req_valid <= 1'b0;
         cmd_ready <= 1'b1;
      end else if (!lnk.req_valid) begin
         cmd_ready <= 1'b1;
      end
   end

   // programming master, pending command then two-phase transfer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ap_r <= AP_IDLE;
         pend_r <= 1'b0;
         {p_wr_r, p_sec_r} <= 2'b00;
         p_addr_r <= 32'h0000_0000;
         p_wdata_r <= 32'h0000_0000;
         reg_ready <= 1'b0;
         reg_done <= 1'b0;
         reg_err <= 1'b0;
         reg_rdata <= 32'h0000_0000;
         {lnk.psel_s, lnk.psel_ns, lnk.penable, lnk.pwrite} <= 4'h0;
         lnk.paddr <= 32'h0000_0000;
         lnk.pwdata <= 32'h0000_0000;
      end else begin
         reg_done <= 1'b0;
         reg_ready <= ~pend_r & ~(reg_valid & reg_ready);
         if (reg_valid && reg_ready) begin
            pend_r <= 1'b1;
            p_wr_r <= reg_write;
            p_sec_r <= reg_secure;
            p_addr_r <= reg_addr;
            p_wdata_r <= reg_wdata;
         end
         if (pclken_r) begin
            unique case (ap_r)
               AP_IDLE: begin
                  if (pend_r) begin
                     lnk.psel_s <= p_sec_r;
                     lnk.psel_ns <= ~p_sec_r;
                     lnk.pwrite <= p_wr_r;
                     lnk.paddr <= p_addr_r;
                     lnk.pwdata <= p_wdata_r;
                     ap_r <= AP_SETUP;
                  end
               end
               AP_SETUP: begin
                  lnk.penable <= 1'b1;
                  ap_r <= AP_ACC;
               end
               AP_ACC: begin
                  if (lnk.pready) begin
                     {lnk.psel_s, lnk.psel_ns, lnk.penable} <= 3'b000;
                     reg_rdata <= lnk.prdata;
                     reg_err <= lnk.pslverr;
                     reg_done <= 1'b1;
                     pend_r <= 1'b0;
                     ap_r <= AP_IDLE;
                  end
               end
               default: ap_r <= AP_IDLE;
            endcase
         end
      end
   end

   // snoop source; absent channel keeps valid low
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lnk.ac_valid <= 1'b0;
         lnk.ac_op <= 2'b00;
         lnk.ac_ctx <= '0;
         mnt_ready <= 1'b0;
         sync_seen <= 1'b0;
      end else begin
         sync_seen <= lnk.sync_done;
         if (mnt_valid && mnt_ready && DVM_PRESENT) begin
            mnt_ready <= 1'b0;
            lnk.ac_valid <= 1'b1;
            lnk.ac_op <= mnt_op;
            lnk.ac_ctx <= mnt_ctx;
         end else if (lnk.ac_valid && lnk.ac_ready) begin
            lnk.ac_valid <= 1'b0;
            mnt_ready <= 1'b1;
         end else if (!lnk.ac_valid) begin
            mnt_ready <= DVM_PRESENT;
         end
      end
   end
endmodule : smu_host

// [src/smu_link_if.sv]
// Purpose: link between the translation shell and its system end
// Assumes: both ends on ref_clk
// Notes: request, programming and maintenance groups
`timescale 1ns/10ps
interface smu_link_if;
   import smu_pkg::*;
   // upstream address request
   logic req_valid;
   logic req_ready;
   logic req_write;
   logic [IA_W-1:0] req_addr;
   logic [2:0] req_prot;
   logic [1:0] req_lock;
   logic [SID_W-1:0] req_sid;
   logic [SSD_W-1:0] req_ssd;
   logic req_bar;
   // programming port
   logic pclken;
   logic psel_s;
   logic psel_ns;
   logic penable;
   logic pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // maintenance snoop channel
   logic ac_valid;
   logic ac_ready;
   logic [1:0] ac_op;
   logic [CTX_W-1:0] ac_ctx;
   logic sync_done;
   modport dev (
      input req_valid, req_write, req_addr, req_prot, req_lock, req_sid, req_ssd, req_bar,
      output req_ready,
      input pclken, psel_s, psel_ns, penable, pwrite, paddr, pwdata,
      output prdata, pready, pslverr,
      input ac_valid, ac_op, ac_ctx,
      output ac_ready, sync_done
   );
   modport sys (
      output req_valid, req_write, req_addr, req_prot, req_lock, req_sid, req_ssd, req_bar,
      input req_ready,
      output pclken, psel_s, psel_ns, penable, pwrite, paddr, pwdata,
      input prdata, pready, pslverr,
      output ac_valid, ac_op, ac_ctx,
      input ac_ready, sync_done
   );
endinterface : smu_link_if

// [src/smu_pkg.sv]
// Purpose: shared constants and types for the translation shell and its system end
// Assumes: one core clock, single-level walk table, address channels only on the link
// Notes: register indices are word indices taken from paddr[15:2]
package smu_pkg;
   localparam int SID_W = 4;
   localparam int CTX_N = 8;
   localparam int CTX_W = 3;
   localparam int SSD_W = 5;
   localparam int IA_W = 32;
   localparam int OA_W = 40;
   localparam int PG_W = 12;
   localparam int WD_W = 64;
   localparam int IDX_W = 14;
   // data path protocol choice
   typedef enum logic [1:0] {
      MODE_AXI3 = 2'b00,
      MODE_AXI4 = 2'b01,
      MODE_ACEL = 2'b10
   } smu_mode_t;
   // maintenance message codes
   typedef enum logic [1:0] {
      DVM_TLBI_ALL = 2'b00,
      DVM_TLBI_CTX = 2'b01,
      DVM_TLBI_IPA = 2'b10,
      DVM_SYNC = 2'b11
   } smu_dvm_t;
   // register word indices
   localparam logic [IDX_W-1:0] REG_SMAP = 14'h0000;
   localparam logic [IDX_W-1:0] REG_TTB = 14'h0040;
   localparam logic [IDX_W-1:0] REG_SSD = 14'h0080;
   localparam logic [IDX_W-1:0] REG_CNT_REF = 14'h00C0;
   localparam logic [IDX_W-1:0] REG_CNT_RD = 14'h00C1;
   localparam logic [IDX_W-1:0] REG_CNT_WR = 14'h00C2;
   localparam logic [IDX_W-1:0] REG_TLBI = 14'h00C3;
   localparam logic [IDX_W-1:0] REG_SYNC = 14'h00C4;
   // field positions and reset values
   localparam int PROT_NS_BIT = 1;
   localparam int LOCK_LK_BIT = 1;
   localparam int DESC_V_BIT = 0;
   localparam int TTB_SH = 8;
   localparam int WIX_W = 9;
   localparam logic [31:0] SSD_RST = 32'h0000_0000;
endpackage : smu_pkg

// [verif/smu_link_sva.sv]
// Purpose: link checks between the shell and its system end
// Assumes: single clock, programming enable tied high
// Notes: sees link signals only
`timescale 1ns/10ps
module smu_link_sva
   import smu_pkg::*;
(
   // clock, reset and link
   input wire logic ref_clk, arst_n, req_valid, req_ready, pclken, psel_s, psel_ns,
   input wire logic penable, pready, pslverr, ac_valid, ac_ready, sync_done,
   input wire logic [1:0] ac_op,
   input wire logic [31:0] req_addr, paddr,
   input wire logic [SID_W-1:0] req_sid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // request take, programming access, sync handshake
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_acc; pclken && (psel_s || psel_ns) && penable && !pready; endsequence
   sequence s_sync; ac_valid && ac_ready && ac_op == DVM_SYNC; endsequence
   a_one_flight: assert property (s_take |=> !req_ready)
      else $error("request taken while one in flight");
   a_req_held: assert property (req_valid && !req_ready
      |=> req_valid && $stable(req_addr) && $stable(req_sid)) else $error("request dropped");
   a_sync_answer: assert property (s_sync |-> ##[1:16] sync_done)
      else $error("no sync indication after sync message");
   a_ac_pulse: assert property (ac_ready |=> !ac_ready)
      else $error("snoop ready longer than one cycle");
   a_ac_cause: assert property (ac_ready |-> $past(ac_valid))
      else $error("snoop ready without valid");
   a_apb_answer: assert property (s_acc |=> pready)
      else $error("programming access not answered");
   a_clken_high: assert property (pclken)
      else $error("programming enable low at full rate");
   a_ssd_refuse: assert property (pready && psel_ns && !psel_s && paddr[15:2] == REG_SSD
      |-> pslverr) else $error("security table reached from non-secure port");
endmodule : smu_link_sva

// [verif/system_mmu_translation_shell_test.sv]
// Purpose: bench for the translation shell joined to its system end
// Assumes: 200 MHz ref_clk, walk reads always accepted
// Notes: bench model keeps table bases, security bits and TLB state
`timescale 1ns/10ps
module system_mmu_translation_shell_test;
   import smu_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_bar = 1'b0, reg_valid = 1'b0, reg_write = 1'b0;
   logic reg_secure = 1'b0, mnt_valid = 1'b0, down_ready = 1'b0, walk_rvalid = 1'b0;
   logic cmd_ready, reg_ready, reg_err, reg_done, mnt_ready, sync_seen, down_valid, down_write;
   logic down_bar, down_secure, walk_arvalid;
   logic [31:0] cmd_addr = 32'h0, reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, ssdm = 32'h0;
   logic [2:0] cmd_prot = 3'h0, mnt_ctx = 3'h0, down_prot, down_ctx;
   logic [1:0] cmd_lock = 2'h0, mnt_op = 2'h0, down_lock;
   logic [SID_W-1:0] cmd_sid = 4'h0;
   logic [SSD_W-1:0] cmd_ssd = 5'h0;
   logic [39:0] down_addr, walk_araddr, wa_seen;
   logic [63:0] walk_rdata = 64'h0;
   logic [31:0] ttbm [8];
   // tlb model: context per entry, -1 when empty, round-robin refill pointer
   int tctx [4] = '{default: -1};
   int vic = 0;
   int bad_count = 0, num_checks = 0, nr = 0, nw = 0, nref = 0;
   smu_link_if lnk();
   smu_device smu_device_i (.ref_clk, .arst_n, .lnk, .down_valid, .down_ready, .down_write,
      .down_addr, .down_prot, .down_lock, .down_bar, .down_ctx, .down_secure, .walk_arvalid,
      .walk_arready(1'b1), .walk_araddr, .walk_rvalid, .walk_rdata);
   smu_host smu_host_i (.ref_clk, .arst_n, .lnk, .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr,
      .cmd_prot, .cmd_lock, .cmd_sid, .cmd_ssd, .cmd_bar, .reg_valid, .reg_ready, .reg_write,
      .reg_secure, .reg_addr, .reg_wdata, .reg_rdata, .reg_err, .reg_done, .mnt_valid,
      .mnt_ready, .mnt_op, .mnt_ctx, .sync_seen);
   smu_link_sva smu_link_sva_i (.ref_clk, .arst_n, .req_valid(lnk.req_valid),
      .req_ready(lnk.req_ready), .pclken(lnk.pclken), .psel_s(lnk.psel_s), .psel_ns(lnk.psel_ns),
      .penable(lnk.penable), .pready(lnk.pready), .pslverr(lnk.pslverr), .ac_valid(lnk.ac_valid),
      .ac_ready(lnk.ac_ready), .sync_done(lnk.sync_done), .ac_op(lnk.ac_op),
      .req_addr(lnk.req_addr), .paddr(lnk.paddr), .req_sid(lnk.req_sid));
   always #2.5 ref_clk = ~ref_clk;
   // read-only walk port, random downstream stalls
   always @(posedge ref_clk) begin
      down_ready <= 1'($urandom);
      walk_rvalid <= walk_arvalid;
      walk_rdata <= walk_arvalid ? {24'h0, walk_araddr[39:12] ^ 28'h0A5A5A5, 12'h001} : ~walk_rdata;
      if (walk_arvalid) wa_seen <= walk_araddr;
   end
   task automatic chk(input logic [63:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rg(input logic w, sec, input logic [31:0] a, d);
      @(posedge ref_clk);
      reg_valid <= 1'b1; reg_write <= w; reg_secure <= sec; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk iff reg_ready);
      reg_valid <= 1'b0;
      @(posedge ref_clk iff reg_done);
   endtask : rg
   task automatic mn(input logic [1:0] op, input logic [2:0] c);
      @(posedge ref_clk);
      mnt_valid <= 1'b1; mnt_op <= op; mnt_ctx <= c;
      @(posedge ref_clk iff mnt_ready);
      mnt_valid <= 1'b0;
      @(posedge ref_clk iff lnk.ac_valid && lnk.ac_ready);
      if (op == DVM_SYNC) @(posedge ref_clk iff sync_seen);
   endtask : mn
   task automatic rq(input logic w, b, input logic [31:0] a, input logic [3:0] s);
      logic [2:0] c;
      logic [39:0] wae;
      logic [49:0] ex;
      int lat;
      logic hit;
      c = 3'(s + 4'h3);
      wae = {ttbm[c], 8'h00} + {a[20:12], 3'b0};
      hit = 1'b0;
      foreach (tctx[i]) if (tctx[i] == int'(c)) hit = 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b1; cmd_write <= w; cmd_bar <= b; cmd_addr <= a; cmd_sid <= s;
      cmd_prot <= 3'($urandom); cmd_lock <= 2'($urandom); cmd_ssd <= 5'($urandom);
      @(posedge ref_clk iff cmd_ready);
      cmd_valid <= 1'b0;
      ex = {wae[39:12] ^ 28'h0A5A5A5, a[11:0], 1'b0, cmd_lock[0], ssdm[cmd_ssd], cmd_prot, c, w};
      @(posedge ref_clk iff lnk.req_valid && lnk.req_ready);
      lat = 0;
      do begin @(negedge ref_clk); lat++; end while (down_valid !== 1'b1 && lat < 50);
      if (b) chk({down_addr, down_bar}, {8'h0, a, 1'b1});
      else chk({down_addr, down_lock, down_secure, down_prot, down_ctx, down_write}, ex);
      if (b || hit) chk(lat, 2);
      else chk(wa_seen, wae);
      if (!b) begin
         if (!hit) begin
            tctx[vic] = int'(c);
            vic = (vic + 1) % 4;
         end
         nref += int'(!hit); nw += int'(w); nr += int'(!w);
      end
      @(posedge ref_clk iff down_ready);
   endtask : rq
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      #100us;
      bad_count++;
      finish_test();
   end
   initial begin
      logic [1:0] op;
      void'($urandom(32'hA2B5));
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      // map and table bases, junk in the ignored address bits
      for (int s = 0; s < 4; s++) begin
         ttbm[s + 3] = $urandom;
         rg(1'b1, 1'b1, {16'hFFFF, 14'(REG_SMAP + s), 2'b11}, 32'(s + 3));
         rg(1'b1, 1'b0, {16'hA5A5, 14'(REG_TTB + s + 3), 2'b01}, ttbm[s + 3]);
      end
      rg(1'b0, 1'b1, {16'h0, 14'(REG_TTB + 3), 2'b00}, 32'h0);
      chk(reg_rdata, ttbm[3]);
      rg(1'b1, 1'b0, {16'h0, REG_SSD, 2'b00}, 32'hFFFF_FFFF);
      chk(reg_err, 1'b1);
      rg(1'b1, 1'b1, {16'h0, REG_SSD, 2'b00}, 32'h0000_00F0);
      ssdm = 32'h0000_00F0;
      // traffic with ignored, context and full invalidation, then sync
      for (int k = 0; k < 12; k++) begin
         rq(1'($urandom), 1'b0, {20'(k % 4 * 257 + 3), 12'($urandom)}, 4'(k % 4));
         if (k % 3 == 2) begin
            op = 2'(2 - k / 3);
            mn(op, 3'h5);
            foreach (tctx[i])
               if ((op == DVM_TLBI_CTX && tctx[i] == 5) || op == DVM_TLBI_ALL) tctx[i] = -1;
         end
      end
      for (int i = 0; i < 3; i++) begin
         rg(1'b0, 1'b1, {16'h0, 14'(REG_CNT_REF + i), 2'b00}, 32'h0);
         chk(reg_rdata, i == 0 ? nref : i == 1 ? nr : nw);
      end
      rq(1'b0, 1'b1, $urandom, 4'h0);
      finish_test();
   end
endmodule : system_mmu_translation_shell_test
